// file: cfd_bridge.sv
/*
 * Processor-side data and fill handshake of the core-logic bridge.
 * Fill data arrives on a valid/ready stream, is buffered in a 16-word
 * FIFO, and is returned to the processor as fills of up to four beats on the
 * shared data bus. Processor block writes are accepted from the bus.
 * Assumes the tristate wire is resolved outside from the enable outputs.
 */
// Summary of operation
// - Data acknowledge one cycle before each transfer.
// - Bus request exactly one cycle before driving.
// - Fill flag marks returned cache fill data.
// - Buffer select shows fill buffer one/zero.
// - Fill error on bad address while idle, or on fault.
// - Tag driver enable low during fill.
// - Shared 128-bit bidirectional data bus.
// - Eight check bits per 64-bit half.
// - Power good resets sequencers, asserts system reset.
// - Cache release request asserted before fill.
// - Four-bit bidirectional command field codes.
module cfd_bridge (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic power_good_in_i,
    input wire logic [3:0] cmd_in_i,
    output logic [3:0] cmd_out_o,
    output logic cmd_oe_l_o,
    input wire logic bad_addr_i,
    input wire logic err_event_i,
    input wire logic [127:0] data_in_i,
    output logic [127:0] data_out_o,
    output logic data_oe_l_o,
    input wire logic [7:0] ecc_hi_in_i,
    input wire logic [7:0] ecc_lo_in_i,
    output logic [7:0] ecc_hi_out_o,
    output logic [7:0] ecc_lo_out_o,
    input wire logic fill_valid_i,
    output logic fill_ready_o,
    input wire logic [143:0] fill_word_i,
    input wire logic fill_buf_i,
    output logic wr_valid_o,
    output logic [143:0] wr_word_o,
    output logic dack_o,
    output logic data_bus_req_o,
    output logic fill_o,
    output logic return_buffer_select_o,
    output logic fill_error_o,
    output logic drive_tag_ctl_l_o,
    output logic cache_release_request_o,
    output logic sys_reset_o
);
    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic pg_s1_r;
    logic pg_s2_r;
    logic [3:0] cmd_s1_r;
    logic [3:0] cmd_s2_r;
    logic bad_s1_r;
    logic bad_s2_r;

    always_ff @(posedge clk_i) begin
        pg_s1_r <= power_good_in_i;
        pg_s2_r <= pg_s1_r;
        cmd_s1_r <= cmd_in_i;
        cmd_s2_r <= cmd_s1_r;
        bad_s1_r <= bad_addr_i;
        bad_s2_r <= bad_s1_r;
    end

    // Power good forces everything idle as strongly as the system reset.
    logic rst;
    assign rst = sys_rst_i || pg_s2_r;

    always_ff @(posedge clk_i) begin
        sys_reset_o <= rst;
    end

    // ----------------------------------------------------------------
    // Fill buffering
    // ----------------------------------------------------------------
    logic q_valid;
    logic q_ready;
    logic [144:0] q_word;

    cfd_fifo #(
        .WIDTH(cfd_pkg::WORD_W + 1),
        .DEPTH(cfd_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .sys_rst_i(rst),
        .in_valid_i(fill_valid_i),
        .in_ready_o(fill_ready_o),
        .in_data_i({fill_buf_i, fill_word_i}),
        .out_valid_o(q_valid),
        .out_ready_i(q_ready),
        .out_data_o(q_word)
    );

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    cfd_pkg::cfd_state_t state_r;
    logic [1:0] beat_r;
    logic [3:0] wait_r;
    logic write_cmd;

    // A fill starts as soon as one word is queued and ends early if the buffer
    // runs dry, so the producer must keep ahead of the drain to get full fills.
    logic fill_ready;
    assign fill_ready = q_valid;
    assign write_cmd = (cmd_s2_r == cfd_pkg::CMD_WRITE_BLOCK);
    assign q_ready = (state_r == cfd_pkg::ST_DRIVE);

    always_ff @(posedge clk_i) begin
        if (rst) begin
            state_r <= cfd_pkg::ST_IDLE;
            beat_r <= '0;
            wait_r <= '0;
        end else begin
            unique case (state_r)
                cfd_pkg::ST_IDLE: begin
                    beat_r <= '0;
                    if (bad_s2_r) begin
                        state_r <= cfd_pkg::ST_ERROR;
                    end else if (write_cmd) begin
                        state_r <= cfd_pkg::ST_ACCEPT;
                    end else if (fill_ready) begin
                        wait_r <= cfd_pkg::RELEASE_CNT;
                        state_r <= cfd_pkg::ST_RELEASE;
                    end
                end
                cfd_pkg::ST_RELEASE: begin
                    if (wait_r == 4'h1) begin
                        state_r <= cfd_pkg::ST_REQ;
                    end else begin
                        wait_r <= wait_r - 4'h1;
                    end
                end
                cfd_pkg::ST_REQ: begin
                    state_r <= cfd_pkg::ST_DRIVE;
                end
                cfd_pkg::ST_DRIVE: begin
                    beat_r <= beat_r + 2'h1;
                    if (beat_r == cfd_pkg::FILL_BEATS_M1 || !q_valid) begin
                        state_r <= cfd_pkg::ST_IDLE;
                    end
                end
                cfd_pkg::ST_ACCEPT: begin
                    beat_r <= beat_r + 2'h1;
                    if (beat_r == cfd_pkg::FILL_BEATS_M1) begin
                        state_r <= cfd_pkg::ST_IDLE;
                    end
                end
                cfd_pkg::ST_ERROR: begin
                    state_r <= cfd_pkg::ST_IDLE;
                end
                default: begin
                    state_r <= cfd_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Handshake outputs, all registered
    // ----------------------------------------------------------------
    logic drive_next;
    logic more_beats;
    assign more_beats = (beat_r != cfd_pkg::FILL_BEATS_M1);
    assign drive_next = (state_r == cfd_pkg::ST_REQ) ||
                        (state_r == cfd_pkg::ST_DRIVE && more_beats && q_valid);

    // A beat is driven in the cycle after the edge that pops it, one cycle behind its acknowledge.
    logic q_pop;
    assign q_pop = q_ready && q_valid;

    always_ff @(posedge clk_i) begin
        if (rst) begin
            dack_o <= 1'b0;
            data_bus_req_o <= 1'b0;
            cache_release_request_o <= 1'b0;
        end else begin
            // Acknowledge leads each driven or accepted beat by one cycle.
            dack_o <= drive_next ||
                      (state_r == cfd_pkg::ST_IDLE && write_cmd && !bad_s2_r) ||
                      (state_r == cfd_pkg::ST_ACCEPT && more_beats);
            data_bus_req_o <= (state_r == cfd_pkg::ST_REQ) || (state_r == cfd_pkg::ST_DRIVE);
            cache_release_request_o <= (state_r == cfd_pkg::ST_RELEASE) ||
                                       (state_r == cfd_pkg::ST_IDLE && fill_ready &&
                                        !write_cmd && !bad_s2_r);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst) begin
            data_oe_l_o <= 1'b1;
            fill_o <= 1'b0;
            drive_tag_ctl_l_o <= 1'b1;
            data_out_o <= '0;
            ecc_hi_out_o <= '0;
            ecc_lo_out_o <= '0;
        end else begin
            data_oe_l_o <= !q_pop;
            fill_o <= q_pop;
            drive_tag_ctl_l_o <= !(state_r == cfd_pkg::ST_REQ || state_r == cfd_pkg::ST_DRIVE);
            if (q_pop) begin
                data_out_o <= q_word[127:0];
                ecc_lo_out_o <= q_word[135:128];
                ecc_hi_out_o <= q_word[143:136];
            end
        end
    end

    // Buffer select latches while the cache is released, before any beat moves, and holds throughout.
    always_ff @(posedge clk_i) begin
        if (rst) begin
            return_buffer_select_o <= cfd_pkg::RST_BUF_SEL;
        end else if (state_r == cfd_pkg::ST_RELEASE) begin
            return_buffer_select_o <= q_word[144];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst) begin
            fill_error_o <= 1'b0;
        end else begin
            fill_error_o <= (state_r == cfd_pkg::ST_IDLE && bad_s2_r) || err_event_i;
        end
    end

    // Write data stands on the bus in the cycle after each acknowledge, so it is
    // sampled at the end of that cycle, one cycle after each accept beat.
    logic acc_beat_r;

    always_ff @(posedge clk_i) begin
        if (rst) begin
            acc_beat_r <= 1'b0;
            wr_valid_o <= 1'b0;
            wr_word_o <= '0;
        end else begin
            acc_beat_r <= (state_r == cfd_pkg::ST_ACCEPT);
            wr_valid_o <= acc_beat_r;
            if (acc_beat_r) begin
                wr_word_o <= {ecc_hi_in_i, ecc_lo_in_i, data_in_i};
            end
        end
    end

    // The bridge never drives the command lines: cmd_oe_l_o stays high and cmd_out_o holds idle; read issue is left to other logic.
    always_ff @(posedge clk_i) begin
        if (rst) begin
            cmd_out_o <= cfd_pkg::CMD_IDLE;
            cmd_oe_l_o <= 1'b1;
        end else begin
            cmd_out_o <= cfd_pkg::CMD_IDLE;
            cmd_oe_l_o <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_req_before_drive: assert property (@(posedge clk_i) disable iff (rst)
        $fell(data_oe_l_o) |-> $past(data_bus_req_o))
        else $error("bus driven without prior request");
    a_dack_leads_data: assert property (@(posedge clk_i) disable iff (rst)
        $fell(data_oe_l_o) |-> $past(dack_o))
        else $error("data driven without acknowledge");
    a_fill_marks_data: assert property (@(posedge clk_i) disable iff (rst)
        !data_oe_l_o |-> fill_o)
        else $error("driven beat not flagged as fill");
    a_tag_during_fill: assert property (@(posedge clk_i) disable iff (rst)
        fill_o |-> !drive_tag_ctl_l_o)
        else $error("tag drivers off during fill");
    a_sel_stable: assert property (@(posedge clk_i) disable iff (rst)
        fill_o && $past(fill_o) |-> $stable(return_buffer_select_o))
        else $error("buffer select changed in fill");
    a_release_first: assert property (@(posedge clk_i) disable iff (rst)
        $rose(data_bus_req_o) && state_r != cfd_pkg::ST_ACCEPT |-> $past(cache_release_request_o))
        else $error("fill began without cache release");
    a_bad_addr_err: assert property (@(posedge clk_i) disable iff (rst)
        state_r == cfd_pkg::ST_IDLE && bad_s2_r |=> fill_error_o)
        else $error("bad address not flagged");
    a_pgood_reset: assert property (@(posedge clk_i)
        pg_s2_r |=> sys_reset_o && state_r == cfd_pkg::ST_IDLE)
        else $error("power good did not reset");
    a_sel_held: assert property (@(posedge clk_i) disable iff (rst)
        state_r == cfd_pkg::ST_DRIVE |-> $stable(return_buffer_select_o))
        else $error("buffer select moved in fill");

endmodule : cfd_bridge

// file: cfd_cpu_model.sv
/*
 * Processor-side partner: resolves the shared data and check-code lines and
 * drives write beats after each data acknowledge.
 * Assumes the bench pulses start_i before each processor block write.
 */
module cfd_cpu_model (
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic [127:0] wr_base_i,
    input wire logic dack_i,
    input wire logic data_oe_l_i,
    input wire logic [127:0] data_out_i,
    input wire logic [7:0] ecc_hi_out_i,
    input wire logic [7:0] ecc_lo_out_i,
    input wire logic cache_release_request_i,
    output logic [127:0] data_o,
    output logic [7:0] ecc_hi_o,
    output logic [7:0] ecc_lo_o,
    output logic released_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [127:0] drv_r = '0;
    logic [7:0] hi_r = '0;
    logic [7:0] lo_r = '0;
    logic [7:0] cnt_r = '0;

    // Without an acknowledge the lines toggle, so a stale value never passes for data.
    always @(posedge clk_i) begin
        if (start_i) begin
            cnt_r <= 8'h00;
        end else if (dack_i) begin
            cnt_r <= cnt_r + 8'h01;
        end
        if (dack_i && data_oe_l_i) begin
            drv_r <= wr_base_i + {120'h0, cnt_r};
            hi_r <= cnt_r;
            lo_r <= ~cnt_r;
        end else begin
            drv_r <= ~drv_r;
            hi_r <= ~hi_r;
            lo_r <= ~lo_r;
        end
        released_o <= cache_release_request_i;
    end

    assign data_o = data_oe_l_i ? drv_r : data_out_i;
    assign ecc_hi_o = data_oe_l_i ? hi_r : ecc_hi_out_i;
    assign ecc_lo_o = data_oe_l_i ? lo_r : ecc_lo_out_i;
endmodule : cfd_cpu_model

// file: cfd_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides, flip-flop storage.
 * Assumes both sides share clk_i and the synchronous reset.
 */
module cfd_fifo #(
    parameter int WIDTH = 144,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o = mem_r[rd_r];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= rd_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : cfd_fifo

// file: cfd_pkg.sv
/*
 * Package for the processor-side fill data interface: bus widths, command
 * codes, timing constants and state encodings.
 * Assumes a single 200 MHz clock and a synchronous active-high reset.
 */
package cfd_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int DATA_W = 128;
    localparam int ECC_W = 8;
    localparam int CMD_W = 4;
    localparam int WORD_W = DATA_W + 2 * ECC_W;
    localparam int FIFO_DEPTH = 16;
    localparam int BEATS_W = 2;

    // ----------------------------------------------------------------
    // Commands on the shared command field
    // ----------------------------------------------------------------
    localparam logic [3:0] CMD_IDLE = 4'h0;
    localparam logic [3:0] CMD_WRITE_BLOCK = 4'h6;
    localparam logic [3:0] CMD_READ_MISS0 = 4'h8;
    localparam logic [3:0] CMD_READ_MISS1 = 4'h9;
    localparam logic [3:0] CMD_READ = 4'h4;

    // ----------------------------------------------------------------
    // Counts and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] FILL_BEATS_M1 = 2'h3;
    localparam int RELEASE_NS = 10;
    localparam int CLK_NS = 5;
    localparam int RELEASE_CYC = (RELEASE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] RELEASE_CNT = 4'(RELEASE_CYC);
    localparam logic RST_BUF_SEL = 1'b0;

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE    = 6'b000001,
        ST_RELEASE = 6'b000010,
        ST_REQ     = 6'b000100,
        ST_DRIVE   = 6'b001000,
        ST_ACCEPT  = 6'b010000,
        ST_ERROR   = 6'b100000
    } cfd_state_t;

endpackage : cfd_pkg

// file: cpu_fill_data_interface_test.sv
/*
 * Self-checking bench for the fill data bridge: writes, errors, fills
 * through a full buffer, and power-good reset.
 * Assumes the processor model above stands on the shared bus.
 */
module cpu_fill_data_interface_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, power_good_in_i = 1'b0, bad_addr_i = 1'b0, err_event_i = 1'b0;
    logic fill_valid_i = 1'b0, fill_buf_i = 1'b0, start = 1'b0, saw_full = 1'b0, rel_seen = 1'b0;
    logic [3:0] cmd_drv = 4'h0, cmd_in_i, cmd_out_o;
    logic [127:0] wr_base = '0, data_in_i, data_out_o;
    logic [143:0] fill_word_i = '0, wr_word_o;
    logic [7:0] ecc_hi_in_i, ecc_lo_in_i, ecc_hi_out_o, ecc_lo_out_o;
    logic cmd_oe_l_o, data_oe_l_o, fill_ready_o, wr_valid_o, dack_o, data_bus_req_o, fill_o;
    logic return_buffer_select_o, fill_error_o, drive_tag_ctl_l_o, cache_release_request_o, sys_reset_o, released;
    logic p_dack = 1'b0, p2_dack = 1'b0, p_req = 1'b0, p_oe_l = 1'b1;
    logic [144:0] fill_q[$];
    logic [143:0] wr_q[$];
    int n_errors = 0, num_checks = 0, seed = 67, err_cnt = 0;

    assign cmd_in_i = cmd_oe_l_o ? cmd_drv : cmd_out_o;

    cfd_bridge dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .power_good_in_i(power_good_in_i),
        .cmd_in_i(cmd_in_i), .cmd_out_o(cmd_out_o), .cmd_oe_l_o(cmd_oe_l_o), .bad_addr_i(bad_addr_i),
        .err_event_i(err_event_i), .data_in_i(data_in_i), .data_out_o(data_out_o), .data_oe_l_o(data_oe_l_o),
        .ecc_hi_in_i(ecc_hi_in_i), .ecc_lo_in_i(ecc_lo_in_i), .ecc_hi_out_o(ecc_hi_out_o),
        .ecc_lo_out_o(ecc_lo_out_o), .fill_valid_i(fill_valid_i), .fill_ready_o(fill_ready_o),
        .fill_word_i(fill_word_i), .fill_buf_i(fill_buf_i), .wr_valid_o(wr_valid_o), .wr_word_o(wr_word_o),
        .dack_o(dack_o), .data_bus_req_o(data_bus_req_o), .fill_o(fill_o),
        .return_buffer_select_o(return_buffer_select_o), .fill_error_o(fill_error_o),
        .drive_tag_ctl_l_o(drive_tag_ctl_l_o), .cache_release_request_o(cache_release_request_o),
        .sys_reset_o(sys_reset_o));

    cfd_cpu_model cpu_u (.clk_i(clk_i), .start_i(start), .wr_base_i(wr_base), .dack_i(dack_o),
        .data_oe_l_i(data_oe_l_o), .data_out_i(data_out_o), .ecc_hi_out_i(ecc_hi_out_o),
        .ecc_lo_out_i(ecc_lo_out_o), .cache_release_request_i(cache_release_request_o),
        .data_o(data_in_i), .ecc_hi_o(ecc_hi_in_i), .ecc_lo_o(ecc_lo_in_i), .released_o(released));

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    task chk_w(input logic [143:0] got, input logic [143:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_w

    task chk_b(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s: got %b expected %b", $time, what, got, exp);
        end
    endtask : chk_b

    task stop_test;
        $display("Checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    // Outputs are all registered, so the falling edge sees them settled.
    always @(negedge clk_i) begin
        if (!sys_rst_i && !power_good_in_i) begin
            if (cache_release_request_o && released) rel_seen = 1'b1;
            if (!data_oe_l_o) begin
                chk_b(p_dack, 1'b1, "ack before drive");
                chk_b(drive_tag_ctl_l_o, 1'b0, "tag drivers");
                chk_b(fill_o, 1'b1, "fill flag");
                if (p_oe_l) chk_b(p_req, 1'b1, "request before drive");
                if (p_oe_l) chk_b(rel_seen, 1'b1, "release before fill");
                if (fill_q.size() == 0) chk_b(1'b1, 1'b0, "unexpected fill beat");
                else begin
                    chk_w({ecc_hi_out_o, ecc_lo_out_o, data_out_o}, fill_q[0][143:0], "fill word");
                    chk_b(return_buffer_select_o, fill_q[0][144], "buffer select");
                    void'(fill_q.pop_front());
                end
            end else if (!p_oe_l) rel_seen = 1'b0;
            if (wr_valid_o) begin
                chk_b(p2_dack, 1'b1, "ack before accept");
                if (wr_q.size() == 0) chk_b(1'b1, 1'b0, "unexpected write beat");
                else chk_w(wr_word_o, wr_q.pop_front(), "write word");
            end
            if (fill_error_o) err_cnt++;
        end
        p2_dack = p_dack;
        p_dack = dack_o;
        p_req = data_bus_req_o;
        p_oe_l = data_oe_l_o;
    end

    task wait_empty;
        for (int k = 0; k < 400 && (fill_q.size() + wr_q.size()) > 0; k++) @(posedge clk_i);
        chk_b((fill_q.size() + wr_q.size()) == 0, 1'b1, "queues drained");
        repeat (4) @(posedge clk_i);
    endtask : wait_empty

    task push_fill(input logic [143:0] w, input logic b);
        logic rdy;
        int k;
        fill_word_i <= w;
        fill_buf_i <= b;
        fill_valid_i <= 1'b1;
        fill_q.push_back({b, w});
        k = 0;
        do begin
            @(negedge clk_i);
            rdy = fill_ready_o;
            if (!rdy) saw_full = 1'b1;
            @(posedge clk_i);
            k++;
        end while (!rdy && k < 200);
    endtask : push_fill

    task send_cmd(input logic [3:0] c);
        start <= 1'b1;
        cmd_drv <= c;
        @(posedge clk_i);
        start <= 1'b0;
        cmd_drv <= cfd_pkg::CMD_IDLE;
        repeat (14) @(posedge clk_i);
    endtask : send_cmd

    initial begin
        logic b;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        chk_b(sys_reset_o, 1'b1, "reset output");
        chk_b(data_oe_l_o, 1'b1, "bus released in reset");
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        $display("Test reset done");

        for (int n = 0; n < 2; n++) begin
            wr_base <= {$random(seed), $random(seed), $random(seed), $random(seed)};
            @(posedge clk_i);
            for (int k = 0; k < 4; k++) wr_q.push_back({8'(k), ~8'(k), wr_base + 128'(k)});
            send_cmd(cfd_pkg::CMD_WRITE_BLOCK);
            wait_empty();
        end
        send_cmd(cfd_pkg::CMD_READ_MISS0);
        chk_b(cmd_oe_l_o, 1'b1, "command lines released");
        $display("Test writes done");

        bad_addr_i <= 1'b1;
        @(posedge clk_i);
        bad_addr_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        err_event_i <= 1'b1;
        @(posedge clk_i);
        err_event_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk_b(err_cnt == 2, 1'b1, "error pulses");
        $display("Test errors done");

        for (int i = 0; i < 40; i++) begin
            if (i % 4 == 0) b = 1'($random(seed));
            push_fill(144'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)}), b);
        end
        fill_valid_i <= 1'b0;
        wait_empty();
        chk_b(saw_full, 1'b1, "buffer refused when full");
        $display("Test fills done");

        power_good_in_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        chk_b(sys_reset_o, 1'b1, "power good reset");
        chk_b(cache_release_request_o | dack_o | fill_o, 1'b0, "sequencers idle");
        @(posedge clk_i);
        power_good_in_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk_b(sys_reset_o, 1'b0, "reset released");
        $display("Test power good done");
        stop_test();
    end

    initial begin
        #(20000 * 5);
        n_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test();
    end
endmodule : cpu_fill_data_interface_test
